//--- pkg/msp_pkg.sv
// Constants and types shared by the signalling PDU mapper.
package msp_pkg;

  // ----------------------------------------------------------------
  // Connection identity values and ranges
  // ----------------------------------------------------------------
  localparam int unsigned CID_W            = 16;
  localparam logic [15:0] BROADCAST_CID    = 16'h0000;
  localparam logic [15:0] MULTI_TERM_CID   = 16'h0001;
  localparam logic [15:0] DUMMY_CID        = 16'h0003;
  localparam logic [15:0] RANGING_CID      = 16'h0004;
  localparam logic [15:0] BASIC_LO         = 16'h000a;
  localparam logic [15:0] BASIC_HI         = 16'h0409;
  localparam logic [15:0] PRIMARY_HI       = 16'h0809;
  localparam logic [15:0] SECONDARY_HI     = 16'h0c09;
  localparam logic [15:0] DATA_LO          = 16'h0c0a;
  localparam logic [15:0] DATA_HI          = 16'hffff;

  typedef enum logic [3:0] {
    CLS_BROADCAST = 4'h0,
    CLS_MULTI     = 4'h1,
    CLS_DUMMY     = 4'h2,
    CLS_RANGING   = 4'h3,
    CLS_BASIC     = 4'h4,
    CLS_PRIMARY   = 4'h5,
    CLS_SECONDARY = 4'h6,
    CLS_DATA      = 4'h7,
    CLS_INVALID   = 4'hf
  } msp_class_e;

  // ----------------------------------------------------------------
  // PDU types, grant kinds and payload sizes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PT_DATA        = 3'h0,
    PT_LONG_SIG    = 3'h1,
    PT_LONG_SEG    = 3'h2,
    PT_SHORT_SIG   = 3'h3,
    PT_LONG_DUMMY  = 3'h4,
    PT_SHORT_DUMMY = 3'h5
  } msp_pdu_e;

  typedef enum logic [1:0] {
    GR_LONG    = 2'h0,
    GR_SHORT   = 2'h1,
    GR_CONTEND = 2'h2,
    GR_RANGING = 2'h3
  } msp_grant_e;

  localparam logic [5:0] LONG_PAYLOAD  = 6'h33;
  localparam logic [5:0] SHORT_PAYLOAD = 6'h08;
  localparam logic [3:0] PHY_MODE_1    = 4'h1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_CLASS  = 4'h8;
  localparam logic [3:0]  REG_ALLOC  = 4'hc;

  localparam int unsigned CTRL_ROLE_BIT   = 0;
  localparam int unsigned CTRL_PAD_LSB    = 4;
  localparam int unsigned CTRL_ROBUST_LSB = 12;
  localparam logic [3:0]  ROBUST_RST      = 4'h1;
  localparam logic [7:0]  PAD_RST         = 8'h00;

  localparam int unsigned ST_SHORT_LONG = 0;
  localparam int unsigned ST_PACK_SEG   = 1;
  localparam int unsigned ST_UL_RSVD    = 2;
  localparam int unsigned ST_INVALID    = 3;
  localparam int unsigned ST_UL_MULTI   = 4;
  localparam int unsigned ST_DL_SHORT   = 5;
  localparam int unsigned ST_W          = 6;

endpackage : msp_pkg

//--- logic/mac_signalling_pdu_mapper.sv
// Connection identity classifier and signalling PDU composer.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module mac_signalling_pdu_mapper #(
  parameter int unsigned PDU_CNT_W = 4
) (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Received header
  input  wire logic        hdrValid,
  input  wire logic [15:0] hdrCid,
  input  wire logic        hdrUplink,
  output logic             clsValid,
  output logic      [3:0]  clsCode,
  output logic             clsInvalid,
  // Grant
  input  wire logic        grantValid,
  input  wire logic [1:0]  grantKind,
  input  wire logic [3:0]  grantPhy,
  input  wire logic [PDU_CNT_W-1:0] grantPdus,
  output logic             grantReady,
  // Message source
  input  wire logic        msgValid,
  input  wire logic [7:0]  msgByte,
  input  wire logic        msgLast,
  input  wire logic [7:0]  msgLen,
  input  wire logic [15:0] msgCid,
  input  wire logic        msgMgmt,
  input  wire logic        msgBwReq,
  input  wire logic        msgPacked,
  input  wire logic        msgSeg,
  input  wire logic        msgMulti,
  input  wire logic        needShortGrant,
  output logic             msgReady,
  output logic             msgReject,
  // Transmit stream
  output logic             txValid,
  output logic      [7:0]  txByte,
  output logic             txStart,
  output logic             txLast,
  output logic      [2:0]  txPduType,
  output logic      [3:0]  txPhyMode,
  output logic      [15:0] txCid,
  output logic             txShortReq
);

  generate
    if (PDU_CNT_W < 1 || PDU_CNT_W > 8) begin : gBadParam
      $error("PDU_CNT_W must lie in 1..8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_COPY = 3'b010,
    S_PAD  = 3'b100
  } msp_state_e;

  localparam int unsigned ST_W_L = msp_pkg::ST_W;

  typedef struct packed {
    msp_state_e          fsm;
    logic [3:0]          cls;
    logic                clsValid;
    logic                clsInvalid;
    logic [15:0]         lastCid;
    logic [2:0]          pduType;
    logic [3:0]          phyMode;
    logic [15:0]         cid;
    logic [7:0]          txByte;
    logic                txValid;
    logic                txStart;
    logic                txLast;
    logic                shortReq;
    logic                reject;
    logic [5:0]          cnt;
    logic [5:0]          payLen;
    logic [PDU_CNT_W-1:0] pduLeft;
    logic                roleAp;
    logic [7:0]          padByte;
    logic [3:0]          robust;
    logic [ST_W_L-1:0]   status;
    logic [15:0]         allocCid;
    logic [31:0]         rdata;
  } msp_state_s;

  msp_state_s q;
  msp_state_s d;

  // ----------------------------------------------------------------
  // Identity decode
  // ----------------------------------------------------------------
  // Values that no class claims fall through to the invalid class.
  function automatic logic [3:0] classOf(input logic [15:0] c);
    logic [3:0] r;
    r = msp_pkg::CLS_INVALID;
    if (c == msp_pkg::BROADCAST_CID) begin
      r = msp_pkg::CLS_BROADCAST;
    end else if (c == msp_pkg::MULTI_TERM_CID) begin
      r = msp_pkg::CLS_MULTI;
    end else if (c == msp_pkg::DUMMY_CID) begin
      r = msp_pkg::CLS_DUMMY;
    end else if (c == msp_pkg::RANGING_CID) begin
      r = msp_pkg::CLS_RANGING;
    end else if (c >= msp_pkg::BASIC_LO && c <= msp_pkg::BASIC_HI) begin
      r = msp_pkg::CLS_BASIC;
    end else if (c > msp_pkg::BASIC_HI && c <= msp_pkg::PRIMARY_HI) begin
      r = msp_pkg::CLS_PRIMARY;
    end else if (c > msp_pkg::PRIMARY_HI && c <= msp_pkg::SECONDARY_HI) begin
      r = msp_pkg::CLS_SECONDARY;
    end else if (c >= msp_pkg::DATA_LO) begin
      r = msp_pkg::CLS_DATA;
    end
    return r;
  endfunction : classOf

  logic [3:0] hdrCls;
  logic [3:0] msgCls;
  assign hdrCls = classOf(hdrCid);
  assign msgCls = classOf(msgCid);

  // ----------------------------------------------------------------
  // Grant decision
  // ----------------------------------------------------------------
  logic isShort;
  logic shortOk;
  logic longBad;
  logic longOk;
  logic [5:0] lastIdx;
  logic [7:0] shortMax;
  logic [7:0] longMax;

  // A message that the grant cannot carry is refused and a dummy of the
  // granted kind goes out instead; a short grant taken as access point sends nothing.
  assign shortMax = {2'b00, msp_pkg::SHORT_PAYLOAD};
  assign longMax  = {2'b00, msp_pkg::LONG_PAYLOAD};
  assign isShort  = grantKind != msp_pkg::GR_LONG;
  assign shortOk  = msgValid && msgMgmt && !msgPacked && !msgSeg && !msgMulti
                    && msgLen <= shortMax
                    && (grantKind != msp_pkg::GR_CONTEND || msgBwReq);
  assign longBad  = (msgPacked && msgSeg)
                    || (msgMulti && (!q.roleAp || msgSeg || msgPacked))
                    || (msgMulti && msgCls != msp_pkg::CLS_MULTI)
                    || msgLen > longMax;
  assign longOk   = msgValid && !longBad;
  assign lastIdx  = q.payLen - 6'h01;

  assign grantReady = clkEn && q.fsm == S_IDLE;
  assign msgReady   = clkEn && q.fsm == S_COPY;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [ST_W_L-1:0] stSet;
    logic [ST_W_L-1:0] stClr;
    logic              endPdu;
    stSet  = '0;
    stClr  = '0;
    endPdu = 1'b0;
    d = q;
    d.clsValid = 1'b0;
    d.txValid  = 1'b0;
    d.txStart  = 1'b0;
    d.txLast   = 1'b0;
    d.reject   = 1'b0;
    d.shortReq = needShortGrant && !q.roleAp;

    if (hdrValid) begin
      d.clsValid   = 1'b1;
      d.cls        = hdrCls;
      d.clsInvalid = hdrCls == msp_pkg::CLS_INVALID;
      d.lastCid    = hdrCid;
      stSet[msp_pkg::ST_INVALID] = hdrCls == msp_pkg::CLS_INVALID;
      stSet[msp_pkg::ST_UL_RSVD] = hdrUplink
        && (hdrCls == msp_pkg::CLS_BROADCAST || hdrCls == msp_pkg::CLS_MULTI
            || hdrCls == msp_pkg::CLS_RANGING);
    end

    case (q.fsm)
      S_IDLE: begin
        if (grantValid) begin
          d.cnt     = '0;
          d.cid     = msgCid;
          d.phyMode = grantPhy;
          if (isShort) begin
            if (q.roleAp) begin
              stSet[msp_pkg::ST_DL_SHORT] = 1'b1;
            end else begin
              d.payLen  = msp_pkg::SHORT_PAYLOAD;
              d.pduLeft = PDU_CNT_W'(1);
              d.pduType = shortOk ? msp_pkg::PT_SHORT_SIG : msp_pkg::PT_SHORT_DUMMY;
              d.fsm     = shortOk ? S_COPY : S_PAD;
              d.reject  = msgValid && !shortOk;
              if (!shortOk) begin
                d.cid = msp_pkg::DUMMY_CID;
              end
              if (grantKind != msp_pkg::GR_SHORT) begin
                d.phyMode = msp_pkg::PHY_MODE_1;
              end
              stSet[msp_pkg::ST_SHORT_LONG] = msgValid && msgMgmt && msgLen > shortMax;
            end
          end else begin
            d.payLen  = msp_pkg::LONG_PAYLOAD;
            d.pduLeft = (grantPdus == '0) ? PDU_CNT_W'(1) : grantPdus;
            d.fsm     = longOk ? S_COPY : S_PAD;
            d.reject  = msgValid && longBad;
            if (!longOk) begin
              d.pduType = msp_pkg::PT_LONG_DUMMY;
              d.cid     = msp_pkg::DUMMY_CID;
            end else if (msgMgmt) begin
              d.pduType = msgSeg ? msp_pkg::PT_LONG_SEG : msp_pkg::PT_LONG_SIG;
            end else begin
              d.pduType = msp_pkg::PT_DATA;
            end
            if (q.roleAp && msgCls == msp_pkg::CLS_BROADCAST) begin
              d.phyMode = q.robust;
            end
            stSet[msp_pkg::ST_PACK_SEG] = msgValid && msgPacked && msgSeg;
            stSet[msp_pkg::ST_UL_MULTI] = msgValid && msgMulti && !q.roleAp;
          end
        end
      end
      S_COPY: begin
        if (msgValid) begin
          d.txValid = 1'b1;
          d.txByte  = msgByte;
          d.txStart = q.cnt == '0;
          d.cnt     = q.cnt + 6'h01;
          if (q.cnt == lastIdx) begin
            endPdu = 1'b1;
          end else if (msgLast) begin
            d.fsm = S_PAD;
          end
        end
      end
      S_PAD: begin
        d.txValid = 1'b1;
        d.txByte  = q.padByte;
        // A follow-on dummy takes its type and identity with its first byte,
        // so the last byte of the PDU before it still shows its own.
        if (q.txLast) begin
          d.pduType = msp_pkg::PT_LONG_DUMMY;
          d.cid     = msp_pkg::DUMMY_CID;
        end
        d.txStart = q.cnt == '0;
        d.cnt     = q.cnt + 6'h01;
        endPdu    = q.cnt == lastIdx;
      end
      default: begin
        d.fsm = S_IDLE;
      end
    endcase

    if (endPdu) begin
      d.txLast = 1'b1;
      d.cnt    = '0;
      if (q.pduLeft > PDU_CNT_W'(1)) begin
        d.pduLeft = q.pduLeft - PDU_CNT_W'(1);
        d.fsm     = S_PAD;
      end else begin
        d.fsm = S_IDLE;
      end
    end

    d.rdata = '0;
    if (regWrite) begin
      case (regAddr)
        msp_pkg::REG_CTRL: begin
          d.roleAp  = regWdata[msp_pkg::CTRL_ROLE_BIT];
          d.padByte = regWdata[msp_pkg::CTRL_PAD_LSB +: 8];
          d.robust  = regWdata[msp_pkg::CTRL_ROBUST_LSB +: 4];
        end
        msp_pkg::REG_STATUS: begin
          stClr = regWdata[ST_W_L-1:0];
        end
        msp_pkg::REG_ALLOC: begin
          // Only the access point hands out new data identities.
          if (q.roleAp) begin
            d.allocCid = (q.allocCid == msp_pkg::DATA_HI) ? msp_pkg::DATA_LO
                                                          : q.allocCid + 16'h0001;
          end
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        msp_pkg::REG_CTRL: begin
          d.rdata[msp_pkg::CTRL_ROLE_BIT]        = q.roleAp;
          d.rdata[msp_pkg::CTRL_PAD_LSB +: 8]    = q.padByte;
          d.rdata[msp_pkg::CTRL_ROBUST_LSB +: 4] = q.robust;
        end
        msp_pkg::REG_STATUS: d.rdata[ST_W_L-1:0] = q.status;
        msp_pkg::REG_CLASS:  d.rdata = {q.lastCid, 11'h000, q.clsInvalid, q.cls};
        msp_pkg::REG_ALLOC:  d.rdata = {16'h0000, q.allocCid};
        default:             d.rdata = '0;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    d.status = (q.status & ~stClr) | stSet;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q          <= '0;
      q.fsm      <= S_IDLE;
      q.cls      <= msp_pkg::CLS_INVALID;
      q.payLen   <= msp_pkg::LONG_PAYLOAD;
      q.padByte  <= msp_pkg::PAD_RST;
      q.robust   <= msp_pkg::ROBUST_RST;
      q.allocCid <= msp_pkg::DATA_LO;
      q.cid      <= msp_pkg::DUMMY_CID;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign regRdata   = q.rdata;
  assign clsValid   = q.clsValid;
  assign clsCode    = q.cls;
  assign clsInvalid = q.clsInvalid;
  assign msgReject  = q.reject;
  assign txValid    = q.txValid;
  assign txByte     = q.txByte;
  assign txStart    = q.txStart;
  assign txLast     = q.txLast;
  assign txPduType  = q.pduType;
  assign txPhyMode  = q.phyMode;
  assign txCid      = q.cid;
  assign txShortReq = q.shortReq;

endmodule : mac_signalling_pdu_mapper

//--- verification/msp_peer_rx.sv
// Peer receiver model that collects every transmitted PDU.
`timescale 1ns/10ps
module msp_peer_rx (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       clkEn,
  // Transmit stream
  input wire logic       txValid,
  input wire logic [7:0] txByte,
  input wire logic       txStart,
  input wire logic       txLast,
  input wire logic [2:0] txPduType
);
  logic [7:0] rxBytes[$];
  logic [2:0] rxTypes[$];
  int         rxLens[$];
  int         cnt;

  // A PDU is closed at its last byte; its length is what was seen since its start.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt = 0;
    end else if (txValid === 1'b1 && clkEn === 1'b1) begin
      rxBytes.push_back(txByte);
      cnt = (txStart === 1'b1) ? 1 : cnt + 1;
      if (txLast === 1'b1) begin
        rxTypes.push_back(txPduType);
        rxLens.push_back(cnt);
      end
    end
  end
endmodule : msp_peer_rx

//--- verification/msp_props.sv
// Concurrent checks on the ports of the signalling PDU mapper.
`timescale 1ns/10ps
module msp_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        clkEn,
  // Header, grant and message
  input wire logic        hdrValid,
  input wire logic [15:0] hdrCid,
  input wire logic        clsValid,
  input wire logic [3:0]  clsCode,
  input wire logic        clsInvalid,
  input wire logic        grantValid,
  input wire logic [1:0]  grantKind,
  input wire logic        grantReady,
  input wire logic        msgValid,
  input wire logic        msgPacked,
  input wire logic        msgSeg,
  input wire logic        msgReject,
  // Transmit stream
  input wire logic        txValid,
  input wire logic        txStart,
  input wire logic        txLast,
  input wire logic [2:0]  txPduType,
  input wire logic [15:0] txCid,
  input wire logic [3:0]  txPhyMode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic [5:0] byteCnt;
  logic       hdrIn;
  logic       grIn;
  logic       isShort;
  assign hdrIn   = hdrValid && clkEn;
  assign grIn    = grantValid && grantReady;
  assign isShort = txPduType inside {msp_pkg::PT_SHORT_SIG, msp_pkg::PT_SHORT_DUMMY};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) byteCnt <= 6'h00;
    else if (txValid && clkEn) byteCnt <= txLast ? 6'h00 : byteCnt + 6'h01;
  end

  a_class_next: assert property (hdrIn |=> clsValid)
    else $error("class decode late");
  a_bcast_code: assert property (
    hdrIn && hdrCid == 16'h0000 |=> clsCode == msp_pkg::CLS_BROADCAST)
    else $error("broadcast decode wrong");
  a_second_code: assert property (
    hdrIn && hdrCid inside {[16'h080a:16'h0c09]} |=> clsCode == msp_pkg::CLS_SECONDARY)
    else $error("secondary decode wrong");
  a_data_code: assert property (
    hdrIn && hdrCid >= 16'h0c0a |=> clsCode == msp_pkg::CLS_DATA && !clsInvalid)
    else $error("data decode wrong");
  a_unassigned_flag: assert property (
    hdrIn && (hdrCid == 16'h0002 || hdrCid inside {[16'h0005:16'h0009]})
    |=> clsInvalid && clsCode == 4'hf)
    else $error("unassigned identity not flagged");
  a_short_size: assert property (
    txValid && txLast && isShort |-> byteCnt == 6'h07)
    else $error("short PDU not eight bytes");
  a_long_size: assert property (
    txValid && txLast && !isShort |-> byteCnt == 6'h32)
    else $error("long PDU not 51 bytes");
  a_contend_phy: assert property (
    grIn && grantKind == msp_pkg::GR_CONTEND |=> txPhyMode == msp_pkg::PHY_MODE_1 && isShort)
    else $error("contention PDU wrong");
  a_dummy_cid: assert property (
    txValid && txPduType inside {msp_pkg::PT_LONG_DUMMY, msp_pkg::PT_SHORT_DUMMY}
    |-> txCid == msp_pkg::DUMMY_CID)
    else $error("dummy PDU identity wrong");
  a_pack_seg: assert property (
    grIn && grantKind == msp_pkg::GR_LONG && msgValid && msgPacked && msgSeg |=> msgReject)
    else $error("packed segment accepted");
  a_start_busy: assert property (txStart |-> !grantReady)
    else $error("grant accepted inside a burst");

  c_short: cover property (txValid && txLast && isShort);
  c_seg: cover property (txLast && txPduType == msp_pkg::PT_LONG_SEG);
  c_reject: cover property (msgReject);
endmodule : msp_props

bind mac_signalling_pdu_mapper msp_props u_props (.*);

//--- verification/tb.sv
// Self-checking testbench for the signalling PDU mapper.
`timescale 1ns/10ps
module tb;
  logic        clock = 1'b0, rst_b = 1'b0, clkEn = 1'b1, needShortGrant = 1'b0;
  logic        regWrite = 1'b0, regRead = 1'b0, hdrValid = 1'b0, hdrUplink = 1'b0;
  logic [3:0]  regAddr = 4'h0, grantPhy = 4'h0, grantPdus = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, rv;
  logic [15:0] hdrCid = 16'h0, msgCid = 16'h0, txCid;
  logic [1:0]  grantKind = 2'h0;
  logic        grantValid = 1'b0, mOn = 1'b0, msgMgmt = 1'b0, msgBwReq = 1'b0;
  logic        msgPacked = 1'b0, msgSeg = 1'b0, msgMulti = 1'b0, rej;
  logic [7:0]  mIdx = 8'h0, nBytes = 8'h0, msgByte, msgLen, txByte;
  logic        msgValid, msgLast, msgReady, msgReject, clsValid, clsInvalid, grantReady;
  logic        txValid, txStart, txLast, txShortReq;
  logic [3:0]  clsCode, txPhyMode, phy;
  logic [2:0]  txPduType;
  int          n_fail = 0, checks = 0, cyc = 0;

  assign msgValid = mOn;
  assign msgByte  = 8'h10 + mIdx;
  assign msgLast  = mIdx == nBytes - 8'h01;
  assign msgLen   = nBytes;

  mac_signalling_pdu_mapper #(.PDU_CNT_W(4)) DUT (.*);
  msp_peer_rx peer (.*);

  always #20 clock = ~clock;

  // ----------------------------------------------------------------
  // Message source and run control
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (msgValid && msgReady) begin
      mIdx <= mIdx + 8'h01;
      if (msgLast) mOn <= 1'b0;
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // Bus and grant tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge clock) regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clock) regRead <= 1'b0;
    @(negedge clock) rv = regRdata;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask : rchk

  // Attribute order is mgmt, bandwidth request, packed, segmented, multi-terminal.
  task automatic grant(input logic [1:0] k, input logic [3:0] n, input logic [7:0] nb,
                       input logic [4:0] at, input logic [15:0] c);
    peer.rxTypes.delete();
    peer.rxLens.delete();
    peer.rxBytes.delete();
    rej = 1'b0;
    phy = 4'h0;
    @(posedge clock);
    {grantKind, grantPdus, grantPhy, grantValid} <= {k, n, 4'h5, 1'b1};
    {msgMgmt, msgBwReq, msgPacked, msgSeg, msgMulti} <= at;
    {msgCid, mIdx, nBytes, mOn} <= {c, 8'h00, nb, nb != 8'h00};
    @(posedge clock) grantValid <= 1'b0;
    for (int t = 0; t < 400; t++) begin
      @(negedge clock);
      if (msgReject === 1'b1) rej = 1'b1;
      if (txStart === 1'b1 && phy == 4'h0) phy = txPhyMode;
      if (grantReady === 1'b1) break;
    end
    @(posedge clock) mOn <= 1'b0;
    @(negedge clock);
  endtask : grant

  task automatic pdus(input int n, input logic [2:0] t0, input int len);
    chk(peer.rxTypes.size(), n);
    foreach (peer.rxTypes[i]) begin
      chk(peer.rxTypes[i], i == 0 ? t0 : msp_pkg::PT_LONG_DUMMY);
      chk(peer.rxLens[i], len);
    end
  endtask : pdus

  task automatic sg(input logic [1:0] k, input logic [4:0] at, input logic [7:0] nb,
                    input logic [2:0] t, input logic r);
    grant(k, 4'h1, nb, at, 16'h000a);
    pdus(1, t, 8);
    chk(rej, r);
  endtask : sg

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rchk(msp_pkg::REG_CTRL, 32'h0000_1000);
    rchk(msp_pkg::REG_ALLOC, 32'h0000_0c0a);
    rchk(4'h2, 32'h0);
    rchk(msp_pkg::REG_STATUS, 32'h0);
    chk({clsCode, txCid}, 32'h000f_0003);
  endtask : t_regs

  task automatic t_class();
    logic [15:0] cids[16] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
      16'h0009, 16'h000a, 16'h0409, 16'h040a, 16'h0809, 16'h080a, 16'h0c09, 16'h0c0a,
      16'h1234, 16'hffff};
    logic [3:0] cls[16] = '{4'h0, 4'h1, 4'hf, 4'h2, 4'h3, 4'hf, 4'hf, 4'h4, 4'h4, 4'h5,
      4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7};
    for (int i = 0; i <= 16; i++) begin
      @(posedge clock);
      {hdrValid, hdrCid} <= {i < 16, cids[i % 16]};
      @(negedge clock);
      if (i > 0) chk({clsValid, clsInvalid, clsCode}, {1'b1, cls[i-1] == 4'hf, cls[i-1]});
    end
    rchk(msp_pkg::REG_CLASS, 32'hffff_0007);
    @(posedge clock);
    {hdrUplink, hdrValid, hdrCid} <= {2'b11, 16'h0004};
    @(posedge clock) hdrValid <= 1'b0;
    rchk(msp_pkg::REG_STATUS, 32'h0000_000c);
    wr(msp_pkg::REG_STATUS, 32'h0000_000c);
    rchk(msp_pkg::REG_STATUS, 32'h0);
  endtask : t_class

  task automatic t_short();
    wr(msp_pkg::REG_CTRL, 32'h0000_1a50);
    @(posedge clock) needShortGrant <= 1'b1;
    sg(msp_pkg::GR_SHORT, 5'h10, 8'h03, msp_pkg::PT_SHORT_SIG, 1'b0);
    for (int i = 0; i < 8; i++) chk(peer.rxBytes[i], i < 3 ? 8'h10 + i : 8'ha5);
    sg(msp_pkg::GR_CONTEND, 5'h18, 8'h02, msp_pkg::PT_SHORT_SIG, 1'b0);
    chk(phy, msp_pkg::PHY_MODE_1);
    sg(msp_pkg::GR_CONTEND, 5'h10, 8'h02, msp_pkg::PT_SHORT_DUMMY, 1'b1);
    sg(msp_pkg::GR_RANGING, 5'h10, 8'h04, msp_pkg::PT_SHORT_SIG, 1'b0);
    sg(msp_pkg::GR_SHORT, 5'h00, 8'h00, msp_pkg::PT_SHORT_DUMMY, 1'b0);
    sg(msp_pkg::GR_SHORT, 5'h10, 8'h09, msp_pkg::PT_SHORT_DUMMY, 1'b1);
    sg(msp_pkg::GR_SHORT, 5'h14, 8'h03, msp_pkg::PT_SHORT_DUMMY, 1'b1);
    @(negedge clock) chk(txShortReq, 1'b1);
    rd(msp_pkg::REG_STATUS);
    chk(rv[0], 1'b1);
  endtask : t_short

  task automatic t_long();
    grant(msp_pkg::GR_LONG, 4'h3, 8'h04, 5'h00, 16'h0c0a);
    pdus(3, msp_pkg::PT_DATA, 51);
    chk(peer.rxBytes[4], 8'ha5);
    grant(msp_pkg::GR_LONG, 4'h1, 8'h05, 5'h10, 16'h000a);
    pdus(1, msp_pkg::PT_LONG_SIG, 51);
    grant(msp_pkg::GR_LONG, 4'h1, 8'h33, 5'h12, 16'h040a);
    pdus(1, msp_pkg::PT_LONG_SEG, 51);
    grant(msp_pkg::GR_LONG, 4'h1, 8'h34, 5'h12, 16'h040a);
    chk(rej, 1'b1);
    grant(msp_pkg::GR_LONG, 4'h1, 8'h04, 5'h16, 16'h000a);
    chk(rej, 1'b1);
    grant(msp_pkg::GR_LONG, 4'h1, 8'h04, 5'h11, 16'h0001);
    chk(rej, 1'b1);
    rd(msp_pkg::REG_STATUS);
    chk({rv[4], rv[1]}, 2'b11);
  endtask : t_long

  task automatic t_ap();
    wr(msp_pkg::REG_CTRL, 32'h0000_7a51);
    repeat (2) @(negedge clock);
    chk(txShortReq, 1'b0);
    grant(msp_pkg::GR_SHORT, 4'h1, 8'h03, 5'h10, 16'h000a);
    chk(peer.rxTypes.size(), 0);
    grant(msp_pkg::GR_LONG, 4'h1, 8'h06, 5'h11, 16'h0001);
    pdus(1, msp_pkg::PT_LONG_SIG, 51);
    grant(msp_pkg::GR_LONG, 4'h1, 8'h06, 5'h10, 16'h0000);
    chk(phy, 4'h7);
    rd(msp_pkg::REG_STATUS);
    chk(rv[5], 1'b1);
    wr(msp_pkg::REG_ALLOC, 32'h0);
    wr(msp_pkg::REG_ALLOC, 32'h0);
    rchk(msp_pkg::REG_ALLOC, 32'h0000_0c0c);
  endtask : t_ap

  task automatic t_freeze();
    @(posedge clock) clkEn <= 1'b0;
    wr(msp_pkg::REG_ALLOC, 32'h0);
    @(negedge clock) chk(grantReady, 1'b0);
    @(posedge clock) clkEn <= 1'b1;
    rchk(msp_pkg::REG_ALLOC, 32'h0000_0c0c);
  endtask : t_freeze

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_class();
    t_short();
    t_long();
    t_ap();
    t_freeze();
    end_of_test();
  end
endmodule : tb
